// ---- ubrm_pkg.sv ----
// Package with register map, field layout and modes of the serial baud/timing register block.
package ubrm_pkg;
   localparam logic [7:0] OFF_TX_HOLDING = 8'h1c;
   localparam logic [7:0] OFF_BAUD_DIVIDER = 8'h20;
   localparam logic [7:0] OFF_RX_IDLE_LIMIT = 8'h24;
   localparam logic [7:0] OFF_TX_GAP = 8'h28;
   localparam logic [7:0] OFF_SMARTCARD_RATIO = 8'h40;
   localparam logic [7:0] OFF_CARD_ERROR_COUNT = 8'h44;
   localparam logic [7:0] OFF_INFRARED_FILTER = 8'h4c;
   localparam logic [7:0] OFF_BIPHASE_CODING = 8'h50;
   localparam logic [10:0] RATIO_RESET = 11'h174;
   localparam logic [31:0] BIPHASE_RESET = 32'h30011004;
   localparam int DELIM_BIT = 15;
   localparam int FP_LSB = 16;
   localparam int DRIFT_BIT = 30;
   localparam int RX_POL_BIT = 28;
   localparam int RX_PREAMBLE_PATTERN_LSB = 24;
   localparam int RX_PREAMBLE_LENGTH_LSB = 16;
   localparam int TX_POL_BIT = 12;
   localparam int TX_PREAMBLE_PATTERN_LSB = 8;
   localparam int TX_PREAMBLE_LENGTH_LSB = 0;
   localparam logic [4:0] OVER16 = 5'h10;
   localparam logic [4:0] OVER8 = 5'h08;
   localparam logic [3:0] FRAC_STEPS = 4'h8;
   typedef enum logic [1:0]
   {
      UBRM_MODE_ASYNC = 2'b00,
      UBRM_MODE_SYNC = 2'b01,
      UBRM_MODE_SPI = 2'b10,
      UBRM_MODE_CARD = 2'b11
   } ubrm_mode_type;
   typedef enum logic [1:0]
   {
      UBRM_PRE_ALL_ONE = 2'b00,
      UBRM_PRE_ALL_ZERO = 2'b01,
      UBRM_PRE_ZERO_ONE = 2'b10,
      UBRM_PRE_ONE_ZERO = 2'b11
   } ubrm_pattern_type;
   typedef struct packed
   {
      logic drift_active;
      logic rx_biphase_polarity;
      ubrm_pattern_type rx_preamble_pattern;
      logic [3:0] rx_preamble_length;
      logic tx_biphase_polarity;
      ubrm_pattern_type tx_preamble_pattern;
      logic [3:0] tx_preamble_length;
   } ubrm_biphase_type;
   typedef struct packed
   {
      logic valid;
      logic is_command;
      logic [8:0] tx_character;
   } ubrm_char_type;
endpackage

// ---- ubrm_top.sv ----
// Baud generator, time-out, timeguard, smart-card and coding registers behind an AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
module ubrm_top
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire ubrm_pkg::ubrm_mode_type mode_select,
   input wire logic oversample_8x,
   input wire logic variable_delimiter_enable,
   input wire logic char_taken,
   input wire logic char_sent,
   input wire logic rx_char_seen,
   input wire logic idle_restart,
   input wire logic card_error,
   output ubrm_pkg::ubrm_char_type tx_char_out,
   output logic tx_holding_free,
   output logic baud_tick,
   output logic rx_timeout,
   output logic tx_gap_active,
   output logic [7:0] infrared_filter,
   output ubrm_pkg::ubrm_biphase_type biphase_cfg
);
   logic [2:0] fraction_part;
   logic [15:0] clock_divisor;
   logic [15:0] rx_idle_limit;
   logic [7:0] tx_gap_value;
   logic [10:0] card_clock_ratio;
   logic [7:0] card_error_count;
   logic [31:0] biphase_coding;
   logic ph_write;
   logic ph_read;
   logic [7:0] ph_addr;
   logic [31:0] next_rdata;
   logic [31:0] prescale;
   logic [31:0] pre_count;
   logic [3:0] frac_acc;
   logic [15:0] div_count;
   logic pre_tick;
   logic frac_hold;
   logic [15:0] idle_count;
   logic idle_armed;
   logic [7:0] gap_count;

   // Count a saturating value down by one.
   function automatic logic [15:0] dec16(input logic [15:0] v);
      dec16 = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
   endfunction

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Address phase captured; writes land in the data phase.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ph_write <= 1'b0;
         ph_read <= 1'b0;
         ph_addr <= 8'h00;
      end
      else if (hready)
      begin
         ph_write <= hsel && htrans[1] && hwrite;
         ph_read <= hsel && htrans[1] && !hwrite;
         ph_addr <= haddr;
      end
   end

   always_comb
   begin
      next_rdata = 32'h00000000;
      unique case (ph_addr)
         ubrm_pkg::OFF_BAUD_DIVIDER: next_rdata = {13'h0000, fraction_part, clock_divisor};
         ubrm_pkg::OFF_RX_IDLE_LIMIT: next_rdata = {16'h0000, rx_idle_limit};
         ubrm_pkg::OFF_TX_GAP: next_rdata = {24'h000000, tx_gap_value};
         ubrm_pkg::OFF_SMARTCARD_RATIO: next_rdata = {21'h000000, card_clock_ratio};
         ubrm_pkg::OFF_CARD_ERROR_COUNT: next_rdata = {24'h000000, card_error_count};
         ubrm_pkg::OFF_INFRARED_FILTER: next_rdata = {24'h000000, infrared_filter};
         ubrm_pkg::OFF_BIPHASE_CODING: next_rdata = biphase_coding;
         default: next_rdata = 32'h00000000;
      endcase
   end

   // Read data is combinational from the held address so it stands in the data phase.
   assign hrdata = ph_read ? next_rdata : 32'h00000000;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         fraction_part <= 3'h0;
         clock_divisor <= 16'h0000;
         rx_idle_limit <= 16'h0000;
         tx_gap_value <= 8'h00;
         card_clock_ratio <= ubrm_pkg::RATIO_RESET;
         infrared_filter <= 8'h00;
         biphase_coding <= ubrm_pkg::BIPHASE_RESET;
      end
      else if (ph_write)
      begin
         unique case (ph_addr)
            ubrm_pkg::OFF_BAUD_DIVIDER:
            begin
               fraction_part <= hwdata[ubrm_pkg::FP_LSB +: 3];
               clock_divisor <= hwdata[15:0];
            end
            ubrm_pkg::OFF_RX_IDLE_LIMIT: rx_idle_limit <= hwdata[15:0];
            ubrm_pkg::OFF_TX_GAP: tx_gap_value <= hwdata[7:0];
            ubrm_pkg::OFF_SMARTCARD_RATIO: card_clock_ratio <= hwdata[10:0];
            ubrm_pkg::OFF_INFRARED_FILTER: infrared_filter <= hwdata[7:0];
            ubrm_pkg::OFF_BIPHASE_CODING: biphase_coding <= hwdata & 32'h530f130f;
            default: ;
         endcase
      end
   end

   // Holding register: a new write replaces a character that has not been taken yet.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         tx_char_out <= '0;
      end
      else if (ph_write && ph_addr == ubrm_pkg::OFF_TX_HOLDING)
      begin
         tx_char_out.valid <= 1'b1;
         tx_char_out.tx_character <= hwdata[8:0];
         tx_char_out.is_command <= variable_delimiter_enable && hwdata[ubrm_pkg::DELIM_BIT];
      end
      else if (char_taken)
      begin
         tx_char_out.valid <= 1'b0;
      end
   end
   assign tx_holding_free = !tx_char_out.valid;

   // Error counter: an error in the read cycle is kept as a count of one.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         card_error_count <= 8'h00;
      end
      else if (ph_read && ph_addr == ubrm_pkg::OFF_CARD_ERROR_COUNT)
      begin
         card_error_count <= {7'h00, card_error};
      end
      else if (card_error && card_error_count != 8'hff)
      begin
         card_error_count <= card_error_count + 8'h01;
      end
   end

   // Prescale by oversampling or card ratio ahead of the divisor.
   always_comb
   begin
      unique case (mode_select)
         ubrm_pkg::UBRM_MODE_ASYNC: prescale = oversample_8x ? {27'h0, ubrm_pkg::OVER8} : {27'h0, ubrm_pkg::OVER16};
         ubrm_pkg::UBRM_MODE_CARD: prescale = {21'h0, card_clock_ratio};
         default: prescale = 32'h00000001;
      endcase
   end

   // The fraction stretches one prescaled step on fraction_part of every eight divisor passes, giving eighths on average.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || clock_divisor == 16'h0000 || prescale == 32'h0)
      begin
         pre_count <= 32'h0;
         pre_tick <= 1'b0;
      end
      else if (pre_count + 32'h1 >= prescale)
      begin
         pre_count <= 32'h0;
         pre_tick <= 1'b1;
      end
      else
      begin
         pre_count <= pre_count + 32'h1;
         pre_tick <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || clock_divisor == 16'h0000 || prescale == 32'h0)
      begin
         div_count <= 16'h0000;
         frac_acc <= 4'h0;
         frac_hold <= 1'b0;
         baud_tick <= 1'b0;
      end
      else if (pre_tick && frac_hold)
      begin
         frac_hold <= 1'b0;
         baud_tick <= 1'b0;
      end
      else if (pre_tick && div_count + 16'h0001 >= clock_divisor)
      begin
         div_count <= 16'h0000;
         baud_tick <= 1'b1;
         if (frac_acc + {1'b0, fraction_part} >= ubrm_pkg::FRAC_STEPS)
         begin
            frac_acc <= frac_acc + {1'b0, fraction_part} - ubrm_pkg::FRAC_STEPS;
            frac_hold <= 1'b1;
         end
         else
         begin
            frac_acc <= frac_acc + {1'b0, fraction_part};
         end
      end
      else
      begin
         if (pre_tick)
         begin
            div_count <= div_count + 16'h0001;
         end
         baud_tick <= 1'b0;
      end
   end

   // Time-out counts bit periods after the last received character.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || rx_idle_limit == 16'h0000)
      begin
         idle_count <= 16'h0000;
         idle_armed <= 1'b0;
         rx_timeout <= 1'b0;
      end
      else if (rx_char_seen || idle_restart)
      begin
         idle_count <= rx_idle_limit;
         idle_armed <= 1'b1;
         rx_timeout <= 1'b0;
      end
      else if (idle_armed && baud_tick)
      begin
         idle_count <= dec16(idle_count);
         if (idle_count == 16'h0001)
         begin
            rx_timeout <= 1'b1;
            idle_armed <= 1'b0;
         end
      end
   end

   // Timeguard holds the transmitter idle for the programmed bit periods.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || tx_gap_value == 8'h00)
      begin
         gap_count <= 8'h00;
      end
      else if (char_sent)
      begin
         gap_count <= tx_gap_value;
      end
      else if (baud_tick && gap_count != 8'h00)
      begin
         gap_count <= gap_count - 8'h01;
      end
   end
   assign tx_gap_active = gap_count != 8'h00;

   always_comb
   begin
      biphase_cfg.drift_active = biphase_coding[ubrm_pkg::DRIFT_BIT] && mode_select == ubrm_pkg::UBRM_MODE_ASYNC
         && !oversample_8x;
      biphase_cfg.rx_biphase_polarity = biphase_coding[ubrm_pkg::RX_POL_BIT];
      biphase_cfg.rx_preamble_pattern = ubrm_pkg::ubrm_pattern_type'(biphase_coding[ubrm_pkg::RX_PREAMBLE_PATTERN_LSB +: 2]);
      biphase_cfg.rx_preamble_length = biphase_coding[ubrm_pkg::RX_PREAMBLE_LENGTH_LSB +: 4];
      biphase_cfg.tx_biphase_polarity = biphase_coding[ubrm_pkg::TX_POL_BIT];
      biphase_cfg.tx_preamble_pattern = ubrm_pkg::ubrm_pattern_type'(biphase_coding[ubrm_pkg::TX_PREAMBLE_PATTERN_LSB +: 2]);
      biphase_cfg.tx_preamble_length = biphase_coding[ubrm_pkg::TX_PREAMBLE_LENGTH_LSB +: 4];
   end
endmodule
`default_nettype wire

// ---- ubrm_frame_model.sv ----
// Framing-side model that takes held characters and later reports them sent.
`timescale 1ns/10ps
`default_nettype none
module ubrm_frame_model
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic tx_holding_free,
   input wire logic [3:0] delay,
   output logic char_taken,
   output logic char_sent
);
   logic busy;
   logic [3:0] cnt;
   // The delay input lets the bench make the framer prompt or slow.
   always_ff @(posedge sys_clk)
   begin
      char_taken <= 1'h0;
      char_sent <= 1'h0;
      cnt <= cnt + 4'h1;
      if (sys_rst)
      begin
         busy <= 1'h0;
         cnt <= 4'h0;
      end
      else if (cnt == delay && (busy || !tx_holding_free))
      begin
         char_taken <= !busy;
         char_sent <= busy;
         busy <= !busy;
         cnt <= 4'h0;
      end
      else if (!busy && tx_holding_free)
         cnt <= 4'h0;
   end
endmodule
`default_nettype wire

// ---- ubrm_properties.sv ----
// Port-level checks on the baud, timing and coding register block.
`timescale 1ns/10ps
`default_nettype none
module ubrm_properties
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire ubrm_pkg::ubrm_mode_type mode_select,
   input wire logic oversample_8x,
   input wire logic rx_char_seen,
   input wire logic idle_restart,
   input wire ubrm_pkg::ubrm_char_type tx_char_out,
   input wire logic tx_holding_free,
   input wire logic baud_tick,
   input wire logic rx_timeout,
   input wire ubrm_pkg::ubrm_biphase_type biphase_cfg
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   wire logic thr_req = hsel && htrans[1] && hready && haddr == ubrm_pkg::OFF_TX_HOLDING;
   wire logic async = mode_select == ubrm_pkg::UBRM_MODE_ASYNC;
   sequence s_thr_write;
      thr_req && hwrite ##1 1'h1;
   endsequence
   sequence s_thr_read;
      thr_req && !hwrite ##1 1'h1;
   endsequence
   a_free_mirror: assert property (tx_holding_free == !tx_char_out.valid)
      else $error("free flag disagrees with held character");
   a_thr_load: assert property (s_thr_write |=> !tx_holding_free)
      else $error("written character not held");
   a_thr_hidden: assert property (s_thr_read |-> hrdata == 32'h0)
      else $error("holding register read gave data");
   // A mode change ends the spacing check, since the prescaler keeps its count and the next tick can come early.
   a_async16_gap: assert property (baud_tick && async && !oversample_8x |=> (!baud_tick || !async || oversample_8x) [*8])
      else $error("16x ticks too close");
   a_async8_gap: assert property (baud_tick && async && oversample_8x |=> (!baud_tick || !async) [*7])
      else $error("8x ticks too close");
   a_timeout_rearm: assert property (rx_char_seen || idle_restart |=> !rx_timeout)
      else $error("time-out not cleared by re-arm");
   a_timeout_hold: assert property (rx_timeout && !rx_char_seen && !idle_restart |=> rx_timeout)
      else $error("time-out dropped without re-arm");
   a_drift_gate: assert property (biphase_cfg.drift_active |-> async && !oversample_8x)
      else $error("drift recovery outside 16x");
endmodule
bind ubrm_top ubrm_properties checker_i(.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
   .mode_select, .oversample_8x, .rx_char_seen, .idle_restart, .tx_char_out, .tx_holding_free, .baud_tick,
   .rx_timeout, .biphase_cfg);
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the baud, timing and coding register block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic sys_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, hready, hresp, hreadyout;
   logic oversample_8x = 1'h0, variable_delimiter_enable = 1'h0, rx_char_seen = 1'h0, idle_restart = 1'h0;
   logic card_error = 1'h0, char_taken, char_sent, tx_holding_free, baud_tick, rx_timeout, tx_gap_active;
   logic [1:0] htrans = 2'h0;
   logic [3:0] delay = 4'h6;
   logic [7:0] haddr = 8'h0, infrared_filter;
   logic [31:0] hwdata = 32'h0, hrdata, r;
   ubrm_pkg::ubrm_mode_type mode_select = ubrm_pkg::UBRM_MODE_SYNC;
   ubrm_pkg::ubrm_char_type tx_char_out;
   ubrm_pkg::ubrm_biphase_type biphase_cfg;
   int fails = 0, cmp_count = 0, n;
   localparam logic [7:0] OFFS [9] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h40, 8'h44, 8'h4c, 8'h50, 8'h00};
   localparam logic [31:0] RST [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h174, 32'h0, 32'h0, 32'h30011004, 32'h0};
   localparam logic [31:0] FULL [9] = '{32'h0, 32'h7ffff, 32'hffff, 32'hff, 32'h7ff, 32'h0, 32'hff, 32'h530f130f, 32'h0};
   localparam logic [31:0] CH [3] = '{32'h8155, 32'h0055, 32'h81aa};
   assign hready = hreadyout;
   ubrm_top dut(.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .mode_select, .oversample_8x, .variable_delimiter_enable, .char_taken, .char_sent,
      .rx_char_seen, .idle_restart, .card_error, .tx_char_out, .tx_holding_free, .baud_tick, .rx_timeout,
      .tx_gap_active, .infrared_filter, .biphase_cfg);
   ubrm_frame_model partner(.sys_clk, .sys_rst, .tx_holding_free, .delay, .char_taken, .char_sent);
   initial forever #4 sys_clk = ~sys_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic span(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi)
      begin
         fails++;
         $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'h1);
      r = hrdata;
   endtask
   // Ticks are counted after a settling span, so an old divisor's count cannot leak in.
   task automatic rate(input int cyc, input int lo, input int hi);
      int cnt;
      cnt = 0;
      repeat (100) @(posedge sys_clk);
      repeat (cyc)
      begin
         @(posedge sys_clk);
         cnt += int'(baud_tick === 1'h1);
      end
      span(cnt, lo, hi);
   endtask
   task automatic t_reset;
      foreach (OFFS[i])
      begin
         bus(1'h0, OFFS[i], 32'h0);
         chk(r, RST[i]);
      end
      chk(32'(hresp), 32'h0);
      $display("end reset values");
   endtask
   task automatic t_char;
      bus(1'h1, 8'h20, 32'h8);
      bus(1'h1, 8'h28, 32'h3);
      for (int i = 0; i < 3; i++)
      begin
         variable_delimiter_enable <= (i < 2);
         bus(1'h1, 8'h1c, CH[i]);
         @(negedge sys_clk);
         chk(32'(tx_char_out), 32'({1'h1, i == 0, CH[i][8:0]}));
         n = 0;
         do @(posedge sys_clk); while (tx_gap_active !== 1'h1 && ++n < 300);
         chk(32'(tx_holding_free), 32'h1);
         n = 0;
         do @(posedge sys_clk); while (tx_gap_active === 1'h1 && ++n < 300);
         span(n, 15, 26);
      end
      $display("end characters");
   endtask
   task automatic t_regs;
      foreach (OFFS[i])
      begin
         bus(1'h1, OFFS[i], '1);
         bus(1'h0, OFFS[i], 32'h0);
         chk(r, FULL[i]);
      end
      @(negedge sys_clk);
      chk(32'(infrared_filter), 32'hff);
      $display("end register access");
   endtask
   task automatic t_coding;
      logic [1:0] p;
      for (int i = 0; i < 4; i++)
      begin
         p = 2'(i);
         bus(1'h1, 8'h50, {3'h0, p[0], 2'h0, p, 6'h0, p, 3'h0, p[0], 2'h0, p, 6'h0, p});
         @(negedge sys_clk);
         chk(32'(biphase_cfg), 32'({1'h0, p[0], p, 2'h0, p, p[0], p, 2'h0, p}));
      end
      bus(1'h1, 8'h50, 32'h40000000);
      mode_select <= ubrm_pkg::UBRM_MODE_ASYNC;
      @(negedge sys_clk);
      chk(32'(biphase_cfg.drift_active), 32'h1);
      @(posedge sys_clk);
      oversample_8x <= 1'h1;
      @(negedge sys_clk);
      chk(32'(biphase_cfg.drift_active), 32'h0);
      $display("end coding");
   endtask
   task automatic t_baud;
      @(posedge sys_clk);
      mode_select <= ubrm_pkg::UBRM_MODE_SYNC;
      bus(1'h1, 8'h20, 32'h5);
      rate(100, 19, 21);
      bus(1'h1, 8'h20, 32'h0);
      rate(100, 0, 0);
      mode_select <= ubrm_pkg::UBRM_MODE_ASYNC;
      bus(1'h1, 8'h20, 32'h3);
      rate(480, 19, 21);
      oversample_8x <= 1'h0;
      rate(480, 9, 11);
      bus(1'h1, 8'h20, 32'h40001);
      rate(480, 19, 21);
      bus(1'h1, 8'h40, 32'h3);
      bus(1'h1, 8'h20, 32'h2);
      mode_select <= ubrm_pkg::UBRM_MODE_CARD;
      rate(120, 19, 21);
      bus(1'h1, 8'h40, 32'h0);
      rate(120, 0, 0);
      $display("end baud");
   endtask
   task automatic t_err;
      repeat (3)
      begin
         card_error <= 1'h1;
         @(posedge sys_clk);
         card_error <= 1'h0;
         @(posedge sys_clk);
      end
      bus(1'h0, 8'h44, 32'h0);
      chk(r, 32'h3);
      bus(1'h0, 8'h44, 32'h0);
      chk(r, 32'h0);
      $display("end error count");
   endtask
   task automatic t_timeout;
      mode_select <= ubrm_pkg::UBRM_MODE_SYNC;
      bus(1'h1, 8'h20, 32'h8);
      bus(1'h1, 8'h24, 32'h3);
      n = 0;
      do @(posedge sys_clk); while (baud_tick !== 1'h1 && ++n < 300);
      idle_restart <= 1'h1;
      @(posedge sys_clk);
      idle_restart <= 1'h0;
      n = 0;
      do @(posedge sys_clk); while (rx_timeout !== 1'h1 && ++n < 300);
      span(n, 21, 27);
      rx_char_seen <= 1'h1;
      @(posedge sys_clk);
      rx_char_seen <= 1'h0;
      bus(1'h1, 8'h24, 32'h0);
      chk(32'(rx_timeout), 32'h0);
      idle_restart <= 1'h1;
      @(posedge sys_clk);
      idle_restart <= 1'h0;
      repeat (100) @(posedge sys_clk);
      chk(32'(rx_timeout), 32'h0);
      $display("end time-out");
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end
   initial
   begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'h0;
      t_reset();
      t_char();
      t_regs();
      t_coding();
      t_baud();
      t_err();
      t_timeout();
      end_sim();
   end
endmodule
`default_nettype wire
